// [src/dcf_status.sv]
`timescale 1ns/10ps
// How it works
// - Register sits at address 0x14, resets to 0x14A000.
// - Sticky flags hold until host writes one; then update to present.
// - Flags whose enable bit is cleared read as zero.
// - Bit 21 returns live fault pin level, never latched.
// - Calibration-pending bit 15 reads one from power-up until refresh.
// - Write changing output span starts refresh and sets pending flag.
// - Calibration-pending flag is read-only, clears when refresh finishes.
// - Bit 14 is one while output slews, self-clears, resets zero.
// - Restart flag bit 13 set by any reset, cleared by writing one.
// - Bit 8 set on latch mismatch, cleared by writing one.
// - Bits 20 to 16 of readback hold the register address.
module dcf_status
    import dcf_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // Register access
    input  wire dcf_access_t       acc,
    output logic [DCF_W-1:0]       rdata,
    output logic                   rvalid,
    // Span change and refresh handshake
    input  wire logic              span_change,
    input  wire logic              refresh_done,
    output logic                   refresh_start,
    // Status inputs
    input  wire logic              slewing,
    input  wire logic              latch_mismatch,
    input  wire logic              latch_check_en,
    input  wire logic              fault_pin
);
    logic             fault_s;
    logic             cal_pending;
    logic             restart_flag;
    logic             latch_flag;
    logic             wr_hit;
    logic             rd_hit;
    logic [DCF_W-1:0] view;

    // Fault pin arrives from outside the clock domain
    dcf_sync #(.W(1)) u_fault_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .d       (fault_pin),
        .q       (fault_s)
    );

    assign wr_hit = acc.wr && (acc.addr == DCF_ADDR);
    assign rd_hit = acc.rd && (acc.addr == DCF_ADDR);

    // Calibration pending; span change wins since a new span restarts it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cal_pending   <= DCF_RESET_VAL[DCF_CAL_BIT];
            refresh_start <= 1'b0;
        end else begin
            refresh_start <= span_change;
            if (span_change)
                cal_pending <= 1'b1;
            else if (refresh_done)
                cal_pending <= 1'b0;
        end
    end

    // Restart flag: write-one-to-clear, present condition is no reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            restart_flag <= DCF_RESET_VAL[DCF_RST_BIT];
        else if (wr_hit && acc.wdata[DCF_RST_BIT])
            restart_flag <= 1'b0;
    end

    // Latch mismatch: sticky; set wins over clear, update on write-one
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            latch_flag <= DCF_RESET_VAL[DCF_LATCH_BIT];
        else if (latch_mismatch && latch_check_en)
            latch_flag <= 1'b1;
        else if (wr_hit && acc.wdata[DCF_LATCH_BIT])
            latch_flag <= 1'b0;
    end

    always_comb begin
        view                     = '0;
        view[DCF_FAULT_BIT]      = fault_s;
        view[DCF_ADDR_LSB +: 5]  = DCF_ADDR;
        view[DCF_CAL_BIT]        = cal_pending;
        view[DCF_SLEW_BIT]       = slewing;
        view[DCF_RST_BIT]        = restart_flag;
        view[DCF_LATCH_BIT]      = latch_flag && latch_check_en;
    end

    // Readback one cycle after the read strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata  <= DCF_RESET_VAL;
            rvalid <= 1'b0;
        end else begin
            rvalid <= rd_hit;
            if (rd_hit)
                rdata <= view;
        end
    end

    // Calibration refresh tracking
    cal_set_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        span_change |=> cal_pending && refresh_start)
        else $error("span change did not set pending");

    cal_clr_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        refresh_done && !span_change |=> !cal_pending)
        else $error("pending not cleared by refresh");

    cal_hold_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !refresh_done && !span_change && cal_pending |=> cal_pending)
        else $error("pending dropped early");

    start_only_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !span_change |=> !refresh_start)
        else $error("refresh started without span change");

    // Restart flag; a reset is its only source
    restart_hold_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !(wr_hit && acc.wdata[DCF_RST_BIT]) && restart_flag
        |=> restart_flag)
        else $error("restart flag lost");

    restart_post_a: assert property (
        @(posedge sys_clk)
        sys_rst |=> restart_flag && cal_pending)
        else $error("reset did not set flags");

    restart_clr_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        wr_hit && acc.wdata[DCF_RST_BIT] |=> !restart_flag)
        else $error("restart flag not cleared");

    // Latch mismatch flag
    latch_set_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        latch_mismatch && latch_check_en |=> latch_flag)
        else $error("latch mismatch not flagged");

    latch_w1c_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        wr_hit && acc.wdata[DCF_LATCH_BIT] && !latch_mismatch
        |=> !latch_flag)
        else $error("latch flag not cleared");

    latch_hold_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !(wr_hit && acc.wdata[DCF_LATCH_BIT]) && latch_flag |=> latch_flag)
        else $error("latch flag dropped without clear");

    latch_off_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !latch_check_en && !latch_flag |=> !latch_flag)
        else $error("disabled check raised its flag");

    // Readback word and its handshake
    read_view_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        rd_hit |=> rvalid
        && rdata[20:16] == DCF_ADDR && rdata[12:9] == 4'h0
        && rdata[7] == 1'b0
        && rdata[DCF_SLEW_BIT] == $past(slewing))
        else $error("readback word malformed");

    read_en_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        rd_hit && !latch_check_en |=> !rdata[DCF_LATCH_BIT])
        else $error("disabled flag read nonzero");

    fault_live_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        rd_hit |=> rdata[DCF_FAULT_BIT] == $past(fault_s))
        else $error("fault bit not live");

    read_cal_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        rd_hit |=> rdata[DCF_CAL_BIT] == $past(cal_pending))
        else $error("pending bit misplaced");

    read_rst_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        rd_hit |=> rdata[DCF_RST_BIT] == $past(restart_flag))
        else $error("restart bit misplaced");

    read_latch_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        rd_hit && latch_check_en
        |=> rdata[DCF_LATCH_BIT] == $past(latch_flag))
        else $error("latch bit misplaced");

    rvalid_only_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !rd_hit |=> !rvalid)
        else $error("readback without accepted read");

    rdata_hold_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !rd_hit |=> $stable(rdata))
        else $error("readback word changed without read");

    // Main scenarios
    span_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        span_change ##[1:50] !cal_pending);
    w1c_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        restart_flag ##1 !restart_flag);
    latch_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        latch_flag ##1 !latch_flag);
    race_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        latch_mismatch && latch_check_en
        && wr_hit && acc.wdata[DCF_LATCH_BIT] ##1 latch_flag);
    read_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        rd_hit ##1 rvalid);
endmodule

// [common/dcf_pkg.sv]
package dcf_pkg;
    localparam logic [4:0]  DCF_ADDR        = 5'h14;
    localparam int          DCF_W           = 22;
    localparam logic [21:0] DCF_RESET_VAL   = 22'h14a000;
    localparam int          DCF_FAULT_BIT   = 21;
    localparam int          DCF_ADDR_LSB    = 16;
    localparam int          DCF_CAL_BIT     = 15;
    localparam int          DCF_SLEW_BIT    = 14;
    localparam int          DCF_RST_BIT     = 13;
    localparam int          DCF_LATCH_BIT   = 8;
    localparam int          DCF_SYNC_STAGES = 2;

    // Register access strobe from the serial frame decoder
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [21:0] wdata;
    } dcf_access_t;
endpackage

// [src/dcf_sync.sv]
`timescale 1ns/10ps
module dcf_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// [test/dcf_host.sv]
`timescale 1ns/10ps
module dcf_host
    import dcf_pkg::*;
(
    // Clock
    input  wire logic        sys_clk,
    // Register access
    output dcf_access_t      acc,
    input  wire logic [21:0] rdata,
    input  wire logic        rvalid
);
    initial acc = '0;
    // Idle data shows the inverse, so a stale word never looks valid
    task automatic rd(input logic [4:0] a, output logic [21:0] w,
                      output logic v);
        @(posedge sys_clk) #1 acc = '{1'b0, 1'b1, a, 22'h0};
        @(posedge sys_clk) #1 acc = '{1'b0, 1'b0, a, 22'h3fffff};
        v = rvalid;
        w = rdata;
    endtask
    task automatic wr(input logic [4:0] a, input logic [21:0] d);
        @(posedge sys_clk) #1 acc = '{1'b1, 1'b0, a, d};
        @(posedge sys_clk) #1 acc = '{1'b0, 1'b0, a, ~d};
    endtask
endmodule

// [test/digital_diag_status_register_test.sv]
`timescale 1ns/10ps
module digital_diag_status_register_test
    import dcf_pkg::*;
;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, span = 1'b0, done = 1'b0;
    logic        slew = 1'b0, mis = 1'b0, en = 1'b0, fault = 1'b0;
    logic [21:0] rdata, w;
    logic        rvalid, start, v;
    dcf_access_t acc;
    int          n_errors = 0, compares = 0;
    always #20 sys_clk = ~sys_clk;
    dcf_host dcf_host_i (.sys_clk(sys_clk), .acc(acc), .rdata(rdata),
        .rvalid(rvalid));
    dcf_status dcf_status_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .acc(acc), .rdata(rdata), .rvalid(rvalid), .span_change(span),
        .refresh_done(done), .refresh_start(start), .slewing(slew),
        .latch_mismatch(mis), .latch_check_en(en), .fault_pin(fault));
    task automatic chk(string nm, logic [21:0] e, logic [21:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(logic [21:0] e);
        dcf_host_i.rd(DCF_ADDR, w, v);
        chk("rvalid", 22'h1, {21'h0, v});
        chk("word", e, w);
    endtask
    task automatic pulse(ref logic s);
        @(posedge sys_clk) #1 s = 1'b1;
        @(posedge sys_clk) #1 s = 1'b0;
    endtask
    task automatic t_reset;
        sys_rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        rchk(22'h14a000);
    endtask
    task automatic t_clear;
        dcf_host_i.wr(DCF_ADDR, 22'h3fffff);
        rchk(22'h148000);
    endtask
    // Flag kept while disabled, only the read is masked
    task automatic t_latch;
        en = 1'b1;
        pulse(mis);
        rchk(22'h148100);
        en = 1'b0;
        rchk(22'h148000);
        en = 1'b1;
        rchk(22'h148100);
        dcf_host_i.wr(DCF_ADDR, 22'h000100);
        rchk(22'h148000);
    endtask
    // Mismatch and clear in one cycle: the new mismatch must survive
    task automatic t_race;
        en = 1'b1;
        fork
            dcf_host_i.wr(DCF_ADDR, 22'h000100);
            pulse(mis);
        join
        rchk(22'h148100);
        dcf_host_i.wr(DCF_ADDR, 22'h000100);
        en = 1'b0;
        pulse(mis);
        en = 1'b1;
        rchk(22'h148000);
    endtask
    task automatic t_refresh;
        pulse(done);
        rchk(22'h140000);
        pulse(span);
        chk("refresh_start", 22'h1, {21'h0, start});
        rchk(22'h148000);
        pulse(done);
        rchk(22'h140000);
        fork
            pulse(span);
            pulse(done);
        join
        chk("refresh_start", 22'h1, {21'h0, start});
        rchk(22'h148000);
        pulse(done);
        rchk(22'h140000);
    endtask
    // Fault pin lags by its synchroniser, so settle before reading
    task automatic t_live(logic l);
        slew = l;
        fault = l;
        repeat (3) @(posedge sys_clk);
        rchk(l ? 22'h344000 : 22'h140000);
    endtask
    task automatic t_unmapped;
        dcf_host_i.rd(5'h15, w, v);
        chk("rvalid", 22'h0, {21'h0, v});
        chk("rdata", 22'h14a000, rdata);
        dcf_host_i.wr(5'h15, 22'h3fffff);
        rchk(22'h14a000);
    endtask
    task automatic finish_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        finish_test();
    end
    initial begin
        t_reset();
        t_clear();
        t_latch();
        t_race();
        t_refresh();
        t_live(1'b1);
        t_live(1'b0);
        t_reset();
        t_unmapped();
        finish_test();
    end
endmodule
